// >>> rtl/byte_ram.sv
// Single-port-write, registered-read byte memory for the data space
`timescale 1ns/1ps
module byte_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : byte_ram

// >>> rtl/exec_pkg.sv
// Constants, types and encodings shared by the instruction execution block
//
// Overview of operation
// - Table write opcode low two bits: keep, post-increment, post-decrement, pre-increment pointer.
// - Table write copies the latch byte into holding register picked by pointer bits 2..0.
// - Table pointer is a 21-bit byte address over a two-megabyte program space.
// - Pointer bit 0 picks low byte when zero, high byte when one.
// - Pre-increment bumps the pointer first; post forms change it after the write.
// - Table write takes two cycles, latch read and holding write in the second.
// - Zero operand discards the prefetched word: two cycles instead of one.
// - Skipping over a two-word instruction takes three cycles in total.
// - Bank bit zero uses the access bank, one uses the bank select register.
// - Bank bit zero, extended set on, address up to 95: indexed literal offset.
// - Literal XOR combines working register with literal, writes it back, one cycle.
// - Register XOR decodes six-bit prefix, destination, bank bit, address; one cycle.
// - Register XOR result goes to working register or back to the file register.
// - Both XOR forms update only negative and zero flags.
package exec_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // ----------------------------------------------------------------
  // Opcode encodings
  // ----------------------------------------------------------------
  localparam logic [13:0] TBLW_PREFIX = 14'h0003;
  localparam logic [6:0] TSTZ_PREFIX = 7'h33;
  localparam logic [7:0] XORL_PREFIX = 8'h0a;
  localparam logic [5:0] XORF_PREFIX = 6'h06;
  localparam logic [1:0] PTR_KEEP = 2'h0;
  localparam logic [1:0] PTR_POST_INC = 2'h1;
  localparam logic [1:0] PTR_POST_DEC = 2'h2;
  localparam logic [1:0] PTR_PRE_INC = 2'h3;

  // ----------------------------------------------------------------
  // Data addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_WREG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_BSR = 8'h10;
  localparam logic [7:0] OFF_TABLE_POINTER = 8'h14;
  localparam logic [7:0] OFF_TABLE_LATCH = 8'h18;
  localparam logic [7:0] OFF_FSR2 = 8'h1c;
  localparam logic [7:0] OFF_EXEC = 8'h20;
  localparam logic [7:0] OFF_DMEM_ADDR = 8'h24;
  localparam logic [7:0] OFF_DMEM_DATA = 8'h28;
  localparam logic [2:0] HOLD_WINDOW = 3'h2;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_TWO_WORD_BIT = 1;
  localparam int STATUS_N_BIT = 4;
  localparam int STATUS_Z_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    OPK_NONE = 3'b000,
    OPK_TBLW = 3'b001,
    OPK_TSTZ = 3'b010,
    OPK_XORL = 3'b011,
    OPK_XORF = 3'b100
  } op_kind_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } exec_state_t;

endpackage : exec_pkg

// >>> rtl/file_addr_resolve.sv
// Maps an 8-bit file address and bank bit onto the 12-bit data space
`timescale 1ns/1ps
module file_addr_resolve (
  input wire logic [7:0] f,
  input wire logic bank_bit,
  input wire logic [3:0] bank_select,
  input wire logic ext_en,
  input wire logic [11:0] fsr2,
  output logic [11:0] addr
);
  always_comb begin
    if (bank_bit) begin
      addr = {bank_select, f};
    end else if (ext_en && f <= exec_pkg::INDEX_LIMIT) begin
      addr = fsr2 + {4'h0, f};
    end else if (f < exec_pkg::ACCESS_SPLIT) begin
      addr = {4'h0, f};
    end else begin
      addr = {exec_pkg::ACCESS_HIGH_BANK, f};
    end
  end
endmodule : file_addr_resolve

// >>> rtl/insn_exec.sv
// Table write, test-and-skip and XOR execution unit behind an AXI4-Lite slave
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module insn_exec #(
  parameter int DATA_AW = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [15:0] opcode_reg;
  logic [1:0] ctrl_reg;
  logic [7:0] wreg_reg;
  logic [7:0] status_reg;
  logic [3:0] bsr_reg;
  logic [20:0] table_pointer_reg;
  logic [7:0] table_latch_reg;
  logic [11:0] fsr2_reg;
  logic [11:0] dmem_addr_reg;
  logic [7:0][7:0] hold_reg;
  exec_pkg::exec_state_t state_reg;
  exec_pkg::op_kind_t kind_reg;
  logic [1:0] phase_reg;
  logic [1:0] cyc_reg;
  logic [1:0] total_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [11:0] faddr_reg;
  logic skipped_reg;
  logic illegal_reg;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic exec_pkg::op_kind_t decode(input logic [15:0] op);
    if (op[15:2] == exec_pkg::TBLW_PREFIX) begin
      return exec_pkg::OPK_TBLW;
    end else if (op[15:9] == exec_pkg::TSTZ_PREFIX) begin
      return exec_pkg::OPK_TSTZ;
    end else if (op[15:8] == exec_pkg::XORL_PREFIX) begin
      return exec_pkg::OPK_XORL;
    end else if (op[15:10] == exec_pkg::XORF_PREFIX) begin
      return exec_pkg::OPK_XORF;
    end
    return exec_pkg::OPK_NONE;
  endfunction : decode

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge_strb

  logic [7:0] ram_rdata;

  // Returns {hit, data} for a register offset
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    if (w[7:5] == exec_pkg::HOLD_WINDOW) begin
      return {1'b1, 24'h00_0000, hold_reg[w[4:2]]};
    end
    case (w)
      exec_pkg::OFF_INSTR: return {1'b1, 16'h0000, opcode_reg};
      exec_pkg::OFF_CTRL: return {1'b1, 30'h0000_0000, ctrl_reg};
      exec_pkg::OFF_WREG: return {1'b1, 24'h00_0000, wreg_reg};
      exec_pkg::OFF_STATUS: return {1'b1, 24'h00_0000, status_reg};
      exec_pkg::OFF_BSR: return {1'b1, 28'h000_0000, bsr_reg};
      exec_pkg::OFF_TABLE_POINTER: return {1'b1, 11'h000, table_pointer_reg};
      exec_pkg::OFF_TABLE_LATCH: return {1'b1, 24'h00_0000, table_latch_reg};
      exec_pkg::OFF_FSR2: return {1'b1, 20'h0_0000, fsr2_reg};
      exec_pkg::OFF_EXEC: return {1'b1, 23'h00_0000, illegal_reg, 2'h0, total_reg, 2'h0, skipped_reg,
                                  state_reg == exec_pkg::ST_RUN};
      exec_pkg::OFF_DMEM_ADDR: return {1'b1, 20'h0_0000, dmem_addr_reg};
      exec_pkg::OFF_DMEM_DATA: return {1'b1, 24'h00_0000, ram_rdata};
      default: return {1'b0, 32'h0000_0000};
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic wr_fire;
  logic [32:0] wr_old;
  logic [31:0] wr_word;
  logic idle;
  assign wr_fire = !awready && !wready && !bvalid;
  // A process rather than an assign: it must wake on the state that the function reads, not only on its argument
  always_comb begin
    wr_old = reg_read(awaddr_reg);
  end
  assign wr_word = merge_strb(wr_old[31:0], wdata_reg, wstrb_reg);
  assign idle = state_reg == exec_pkg::ST_IDLE;

  function automatic logic sw_wr(input logic [7:0] off);
    return wr_fire && {awaddr_reg[7:2], 2'b00} == off && state_reg == exec_pkg::ST_IDLE;
  endfunction : sw_wr

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= exec_pkg::RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_old[32] ? exec_pkg::RESP_OKAY : exec_pkg::RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic [32:0] rd_val;
  // Polling one address must still see the status move, so this is a process too
  always_comb begin
    rd_val = reg_read(araddr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= exec_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val[31:0];
      rresp <= rd_val[32] ? exec_pkg::RESP_OKAY : exec_pkg::RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: four phases per instruction cycle
  // ----------------------------------------------------------------
  exec_pkg::op_kind_t new_kind;
  logic start;
  logic finish;
  logic at_q1;
  logic at_q2;
  logic at_q3;
  logic [11:0] file_addr;
  logic [1:0] ptr_mode;
  assign new_kind = decode(wr_word[15:0]);
  always_comb begin
    start = sw_wr(exec_pkg::OFF_INSTR) && new_kind != exec_pkg::OPK_NONE;
  end
  assign at_q1 = state_reg == exec_pkg::ST_RUN && phase_reg == 2'h1;
  assign at_q2 = state_reg == exec_pkg::ST_RUN && phase_reg == 2'h2;
  assign at_q3 = state_reg == exec_pkg::ST_RUN && phase_reg == exec_pkg::Q_LAST;
  assign finish = at_q3 && cyc_reg == total_reg - exec_pkg::CYC_ONE;
  assign ptr_mode = opcode_reg[1:0];

  file_addr_resolve u_resolve (
    .f(wr_word[7:0]),
    .bank_bit(wr_word[8]),
    .bank_select(bsr_reg),
    .ext_en(ctrl_reg[exec_pkg::CTRL_EXT_BIT]),
    .fsr2(fsr2_reg),
    .addr(file_addr)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= exec_pkg::ST_IDLE;
      kind_reg <= exec_pkg::OPK_NONE;
      opcode_reg <= 16'h0000;
      phase_reg <= 2'h0;
      cyc_reg <= 2'h0;
      total_reg <= 2'h0;
      faddr_reg <= 12'h000;
      skipped_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      case (state_reg)
        exec_pkg::ST_IDLE: begin
          if (sw_wr(exec_pkg::OFF_INSTR)) begin
            opcode_reg <= wr_word[15:0];
            illegal_reg <= new_kind == exec_pkg::OPK_NONE;
          end
          if (start) begin
            state_reg <= exec_pkg::ST_RUN;
            kind_reg <= new_kind;
            faddr_reg <= file_addr;
            skipped_reg <= 1'b0;
            phase_reg <= 2'h0;
            cyc_reg <= 2'h0;
            total_reg <= new_kind == exec_pkg::OPK_TBLW ? exec_pkg::CYC_TWO : exec_pkg::CYC_ONE;
          end
        end
        exec_pkg::ST_RUN: begin
          phase_reg <= phase_reg + 2'h1;
          if (at_q2 && kind_reg == exec_pkg::OPK_TSTZ && cyc_reg == 2'h0 && operand_reg == 8'h00) begin
            // The prefetched word is dropped; its slots run as no-operation cycles
            skipped_reg <= 1'b1;
            total_reg <= ctrl_reg[exec_pkg::CTRL_TWO_WORD_BIT] ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO;
          end
          if (finish) begin
            state_reg <= exec_pkg::ST_IDLE;
            cyc_reg <= 2'h0;
          end else if (at_q3) begin
            cyc_reg <= cyc_reg + 2'h1;
          end
        end
        default: state_reg <= exec_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operand fetch and processing
  // ----------------------------------------------------------------
  logic ram_we;
  logic [11:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic xor_file_back;
  assign xor_file_back = at_q3 && kind_reg == exec_pkg::OPK_XORF && opcode_reg[9] && cyc_reg == 2'h0;
  always_comb begin
    ram_we = xor_file_back || sw_wr(exec_pkg::OFF_DMEM_DATA);
  end
  assign ram_waddr = xor_file_back ? faddr_reg : dmem_addr_reg;
  assign ram_wdata = xor_file_back ? result_reg : wr_word[7:0];

  byte_ram #(.AW(DATA_AW), .DW(8)) u_data_ram (
    .clk(aclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(idle ? dmem_addr_reg : faddr_reg),
    .rdata(ram_rdata)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
    end else if (at_q1 && cyc_reg == 2'h0) begin
      operand_reg <= ram_rdata;
    end else if (at_q1 && kind_reg == exec_pkg::OPK_TBLW) begin
      result_reg <= table_latch_reg;
    end else if (at_q2 && cyc_reg == 2'h0) begin
      case (kind_reg)
        exec_pkg::OPK_XORL: result_reg <= wreg_reg ^ opcode_reg[7:0];
        exec_pkg::OPK_XORF: result_reg <= wreg_reg ^ operand_reg;
        default: result_reg <= operand_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  logic xor_done;
  assign xor_done = at_q3 && (kind_reg == exec_pkg::OPK_XORL || kind_reg == exec_pkg::OPK_XORF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wreg_reg <= 8'h00;
    end else if (xor_done && !(kind_reg == exec_pkg::OPK_XORF && opcode_reg[9])) begin
      wreg_reg <= result_reg;
    end else if (sw_wr(exec_pkg::OFF_WREG)) begin
      wreg_reg <= wr_word[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 8'h00;
    end else if (xor_done) begin
      // Only N and Z move; carry and the rest are left as they were
      status_reg[exec_pkg::STATUS_N_BIT] <= result_reg[7];
      status_reg[exec_pkg::STATUS_Z_BIT] <= result_reg == 8'h00;
    end else if (sw_wr(exec_pkg::OFF_STATUS)) begin
      status_reg <= wr_word[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= exec_pkg::CTRL_RESET;
      bsr_reg <= 4'h0;
      table_latch_reg <= 8'h00;
      fsr2_reg <= 12'h000;
      dmem_addr_reg <= 12'h000;
    end else begin
      if (sw_wr(exec_pkg::OFF_CTRL)) begin
        ctrl_reg <= wr_word[1:0];
      end
      if (sw_wr(exec_pkg::OFF_BSR)) begin
        bsr_reg <= wr_word[3:0];
      end
      if (sw_wr(exec_pkg::OFF_TABLE_LATCH)) begin
        table_latch_reg <= wr_word[7:0];
      end
      if (sw_wr(exec_pkg::OFF_FSR2)) begin
        fsr2_reg <= wr_word[11:0];
      end
      if (sw_wr(exec_pkg::OFF_DMEM_ADDR)) begin
        dmem_addr_reg <= wr_word[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Table pointer and holding registers
  // ----------------------------------------------------------------
  logic tbl_pre;
  logic tbl_write;
  assign tbl_pre = state_reg == exec_pkg::ST_RUN && phase_reg == 2'h0 && cyc_reg == 2'h0 &&
                   kind_reg == exec_pkg::OPK_TBLW && ptr_mode == exec_pkg::PTR_PRE_INC;
  assign tbl_write = at_q3 && kind_reg == exec_pkg::OPK_TBLW && cyc_reg == 2'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_pointer_reg <= 21'h00_0000;
    end else if (tbl_pre) begin
      table_pointer_reg <= table_pointer_reg + 21'h00_0001;
    end else if (tbl_write && ptr_mode == exec_pkg::PTR_POST_INC) begin
      table_pointer_reg <= table_pointer_reg + 21'h00_0001;
    end else if (tbl_write && ptr_mode == exec_pkg::PTR_POST_DEC) begin
      table_pointer_reg <= table_pointer_reg - 21'h00_0001;
    end else if (sw_wr(exec_pkg::OFF_TABLE_POINTER)) begin
      table_pointer_reg <= wr_word[20:0];
    end
  end

  // Bit 0 of the index is the byte lane: even slots low bytes, odd slots high bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= '0;
    end else if (tbl_write) begin
      hold_reg[table_pointer_reg[2:0]] <= result_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic start_tbl;
  logic start_xor;
  logic start_tst;
  logic tst_decide;
  assign start_tbl = start && new_kind == exec_pkg::OPK_TBLW;
  assign start_xor = start && (new_kind == exec_pkg::OPK_XORL || new_kind == exec_pkg::OPK_XORF);
  assign start_tst = start && new_kind == exec_pkg::OPK_TSTZ;
  assign tst_decide = at_q2 && kind_reg == exec_pkg::OPK_TSTZ && cyc_reg == 2'h0;

  sequence s_no_finish4;
    !finish [*4];
  endsequence

  a_tblw_two_cycles: assert property (start_tbl |=> s_no_finish4 ##0 1'b1 ##1 !finish [*3] ##1 finish)
    else $error("table write did not end after two cycles");
  a_tblw_no_flags: assert property (start_tbl |=> $stable(status_reg) [*8])
    else $error("table write changed status");
  a_xor_one_cycle: assert property (start_xor |-> ##4 finish)
    else $error("xor did not finish in one cycle");
  a_tst_no_flags: assert property (start_tst |=> $stable(status_reg) [*4])
    else $error("test and skip changed status");
  a_skip_two: assert property (tst_decide && operand_reg == 8'h00 && !ctrl_reg[exec_pkg::CTRL_TWO_WORD_BIT]
                               |-> !finish ##5 finish)
    else $error("skip did not take two cycles");
  a_skip_three: assert property (tst_decide && operand_reg == 8'h00 && ctrl_reg[exec_pkg::CTRL_TWO_WORD_BIT]
                                 |-> ##9 finish)
    else $error("skip over two-word did not take three cycles");
  a_noskip_one: assert property (tst_decide && operand_reg != 8'h00 |-> ##1 finish)
    else $error("non-zero test did not finish in one cycle");
  a_xor_flags: assert property (xor_done |=> status_reg[exec_pkg::STATUS_Z_BIT] == ($past(result_reg) == 8'h00)
                                && status_reg[exec_pkg::STATUS_N_BIT] == $past(result_reg[7]))
    else $error("xor flags wrong");
  a_xorl_result: assert property (start && new_kind == exec_pkg::OPK_XORL
                                  |-> ##5 wreg_reg == ($past(wreg_reg, 5) ^ $past(wr_word[7:0], 5)))
    else $error("literal xor result wrong");
  a_hold_write: assert property (tbl_write |=> hold_reg[$past(table_pointer_reg[2:0])] == $past(table_latch_reg))
    else $error("holding register not written from latch");
  a_hold_stable: assert property (!tbl_write |=> $stable(hold_reg))
    else $error("holding registers changed outside a table write");
  a_ptr_post_dec: assert property (start_tbl && wr_word[1:0] == exec_pkg::PTR_POST_DEC
                                   |-> ##9 table_pointer_reg == $past(table_pointer_reg, 9) - 21'h00_0001)
    else $error("post-decrement pointer wrong");
  a_ptr_pre_inc: assert property (start_tbl && wr_word[1:0] == exec_pkg::PTR_PRE_INC
                                  |-> ##2 table_pointer_reg == $past(table_pointer_reg, 2) + 21'h00_0001)
    else $error("pre-increment not done before the write");
  a_bank_addr: assert property (start && new_kind != exec_pkg::OPK_XORL && new_kind != exec_pkg::OPK_TBLW
                                && wr_word[8] |=> faddr_reg == {$past(bsr_reg), $past(wr_word[7:0])})
    else $error("banked address wrong");
endmodule : insn_exec

// >>> verif/testbench.sv
// Self-checking bench for the table write, skip and XOR unit
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_val;
  logic [1:0] bresp, rresp, resp_val;
  int num_errors = 0, num_checks = 0;
  insn_exec insn_exec_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // One bus cycle; the trailing edge keeps a strobe from being set twice in one step
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    for (n = 0; n < 50 && !(we ? bvalid : rvalid); n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end
    rd_val = rdata;
    resp_val = we ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 50) begin
      num_errors++;
      close_out();
    end
    @(posedge aclk);
  endtask : xfer
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd_val, exp);
  endtask : rchk
  task automatic run(input logic [15:0] op);
    int n;
    xfer(1'b1, 8'h00, 32'(op));
    rd_val = 32'h0000_0001;
    for (n = 0; n < 50 && rd_val[0] !== 1'b0; n++) xfer(1'b0, 8'h20, 32'h0000_0000);
    if (n == 50) begin
      num_errors++;
      close_out();
    end
  endtask : run
  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, 8'h24, 32'(a));
    xfer(1'b1, 8'h28, 32'(d));
  endtask : poke
  task automatic fchk(input logic [11:0] a, input logic [7:0] exp);
    xfer(1'b1, 8'h24, 32'(a));
    rchk(8'h28, 32'(exp));
  endtask : fchk
  task automatic t_table();
    logic [7:0] lat [4] = '{8'h55, 8'h34, 8'h77, 8'h11};
    logic [1:0] md [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic [20:0] p_in [4] = '{21'h0_a356, 21'h1_389a, 21'h0_0000, 21'h0_0005};
    logic [20:0] p_out [4] = '{21'h0_a357, 21'h1_389b, 21'h1f_ffff, 21'h0_0005};
    xfer(1'b1, 8'h0c, 32'h0000_00a5);
    chk(resp_val, exec_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h18, 32'(lat[i]));
      xfer(1'b1, 8'h14, 32'(p_in[i]));
      run({exec_pkg::TBLW_PREFIX, md[i]});
      chk(rd_val[8:0], 9'h020);
      rchk(8'h14, 32'(p_out[i]));
      rchk({3'b010, (md[i] == 2'h3 ? p_out[i][2:0] : p_in[i][2:0]), 2'b00}, 32'(lat[i]));
    end
    rchk(8'h58, 32'h0000_0055);
    rchk(8'h0c, 32'h0000_00a5);
  endtask : t_table
  task automatic t_xor();
    logic [7:0] fo [4] = '{8'h5f, 8'h60, 8'h10, 8'h80};
    logic [11:0] ad [4] = '{12'h35f, 12'hf60, 12'h010, 12'hf80};
    xfer(1'b1, 8'h08, 32'h0000_00b5);
    run(16'h0aaf);
    chk(rd_val[8:0], 9'h010);
    rchk(8'h08, 32'h0000_001a);
    rchk(8'h0c, 32'h0000_00a1);
    run(16'h0aaf);
    xfer(1'b1, 8'h10, 32'h0000_0002);
    poke(12'h234, 8'haf);
    run(16'h1b34);
    chk(rd_val[8:0], 9'h010);
    fchk(12'h234, 8'h1a);
    run(16'h1934);
    rchk(8'h08, 32'h0000_00af);
    rchk(8'h0c, 32'h0000_00b1);
    xfer(1'b1, 8'h1c, 32'h0000_0300);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'h04, 32'(i < 2));
      poke(ad[i], 8'haf);
      run({8'h1a, fo[i]});
      fchk(ad[i], 8'h00);
    end
    rchk(8'h0c, 32'h0000_00a5);
  endtask : t_xor
  task automatic t_skip();
    run(16'h6680);
    chk(rd_val[8:0], 9'h022);
    xfer(1'b1, 8'h04, 32'h0000_0002);
    run(16'h6734);
    chk(rd_val[8:0], 9'h010);
    run(16'h6680);
    chk(rd_val[8:0], 9'h032);
    rchk(8'h0c, 32'h0000_00a5);
    run(16'h0008);
    chk(rd_val[8:0], 9'h132);
    rchk(8'h14, 32'h0000_0005);
  endtask : t_skip
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(8'h04, 32'h0000_0001);
    chk(resp_val, exec_pkg::RESP_OKAY);
    xfer(1'b1, 8'h3c, 32'h1234_5678);
    chk(resp_val, exec_pkg::RESP_DECERR);
    rchk(8'h3c, 32'h0000_0000);
    chk(resp_val, exec_pkg::RESP_DECERR);
    t_table();
    t_xor();
    t_skip();
    close_out();
  end
endmodule : testbench
